/* File: design/switch_regs_pkg.sv */
// constants and types for the switch interrupt and priority register slice
package switch_regs_pkg;

    // register offsets
    localparam logic [7:0] indirect_data_byte0_addr = 8'h78;
    localparam logic [7:0] link_change_irq_status_addr = 8'h7c;
    localparam logic [7:0] link_change_irq_mask_addr = 8'h7d;
    localparam logic [7:0] tag_priority_map_low_addr = 8'h80;
    localparam logic [7:0] tag_priority_map_high_addr = 8'h81;

    // reset values
    localparam logic [7:0] indirect_data_byte0_reset = 8'h00;
    localparam logic [7:0] irq_status_reset = 8'h00;
    localparam logic [7:0] irq_mask_reset = 8'h00;
    // tag three = 1, tag two = 1, tag one = 0, tag zero = 0
    localparam logic [7:0] tag_priority_map_low_reset = 8'h50;
    // tag seven = 3, tag six = 3, tag five = 2, tag four = 2
    localparam logic [7:0] tag_priority_map_high_reset = 8'hfa;

    // field layout
    localparam int port_irq_first_bit = 1;
    localparam int num_ports = 2;
    localparam logic [7:0] port_irq_field = 8'h06;
    localparam int prio_width = 2;
    localparam int tag_width = 3;

    // register access request from the management port
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_type;

    // tagged frame presented for classification
    typedef struct packed {
        logic valid;
        logic [tag_width-1:0] tag;
    } frame_tag_type;

    // classification result
    typedef struct packed {
        logic valid;
        logic [prio_width-1:0] prio;
    } frame_prio_type;

endpackage

/* File: design/tag_priority_lookup.sv */
// maps an 802.1p tag to an internal priority through the two map bytes
`timescale 1ns/100ps
`default_nettype none
module tag_priority_lookup
    import switch_regs_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // map registers
    input wire logic [7:0] map_low,
    input wire logic [7:0] map_high,
    // frame in and result out
    input wire frame_tag_type frame_in,
    output frame_prio_type frame_out
);

    logic [15:0] map_all;
    logic [prio_width-1:0] next_prio;

    assign map_all = {map_high, map_low};

    // tag n reads bits 2n+1:2n of the joined map
    always_comb begin
        next_prio = map_all[{frame_in.tag, 1'b0} +: prio_width];
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            frame_out <= '0;
        end else begin
            frame_out.valid <= frame_in.valid;
            if (frame_in.valid) begin
                frame_out.prio <= next_prio;
            end
        end
    end

endmodule
`default_nettype wire

/* File: design/switch_irq_and_priority_regs.sv */
// switch register slice: indirect data byte, link-change interrupts, tag priority map
`timescale 1ns/100ps
`default_nettype none
module switch_irq_and_priority_regs
    import switch_regs_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // register port
    input wire reg_req_type reg_req,
    output logic [7:0] rd_data,
    output logic rd_valid,
    // link state per port, bit 0 is port one
    input wire logic [num_ports-1:0] link_up,
    // interrupt
    output logic irq,
    // frame classification
    input wire frame_tag_type frame_in,
    output frame_prio_type frame_out,
    // indirect data byte for the table engine
    output logic [7:0] indirect_data_low
);

    ////////////////////////////////////////////////////////////////////////
    // register views

    logic [7:0] indirect_data_byte0;
    logic [7:0] link_change_irq_status;
    logic [7:0] link_change_irq_mask;
    logic [7:0] tag_priority_map_low;
    logic [7:0] tag_priority_map_high;
    logic [7:0] next_rd_data;

    ////////////////////////////////////////////////////////////////////////
    // address decode

    logic sel_indirect;
    logic sel_status;
    logic sel_mask;
    logic sel_map_low;
    logic sel_map_high;
    logic wr_indirect;
    logic wr_status;
    logic wr_mask;
    logic wr_map_low;
    logic wr_map_high;

    // one select per register, unmapped offsets select nothing
    always_comb begin
        sel_indirect = 1'b0;
        sel_status = 1'b0;
        sel_mask = 1'b0;
        sel_map_low = 1'b0;
        sel_map_high = 1'b0;
        case (reg_req.addr)
            indirect_data_byte0_addr: begin
                sel_indirect = 1'b1;
            end
            link_change_irq_status_addr: begin
                sel_status = 1'b1;
            end
            link_change_irq_mask_addr: begin
                sel_mask = 1'b1;
            end
            tag_priority_map_low_addr: begin
                sel_map_low = 1'b1;
            end
            tag_priority_map_high_addr: begin
                sel_map_high = 1'b1;
            end
            default: begin
                sel_indirect = 1'b0;
            end
        endcase
    end

    assign wr_indirect = reg_req.wr && sel_indirect;
    assign wr_status = reg_req.wr && sel_status;
    assign wr_mask = reg_req.wr && sel_mask;
    assign wr_map_low = reg_req.wr && sel_map_low;
    assign wr_map_high = reg_req.wr && sel_map_high;

    ////////////////////////////////////////////////////////////////////////
    // indirect data byte

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            indirect_data_byte0 <= indirect_data_byte0_reset;
        end else if (wr_indirect) begin
            indirect_data_byte0 <= reg_req.wdata;
        end
    end

    assign indirect_data_low = indirect_data_byte0;

    ////////////////////////////////////////////////////////////////////////
    // link change detection

    logic [num_ports-1:0] link_prev;
    logic link_primed;
    logic [num_ports-1:0] link_change;

    // first sample after reset only loads the history, no event
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            link_prev <= '0;
        end else begin
            link_prev <= link_up;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            link_primed <= 1'b0;
        end else begin
            link_primed <= 1'b1;
        end
    end

    assign link_change = link_primed ? (link_up ^ link_prev) : '0;

    ////////////////////////////////////////////////////////////////////////
    // status and mask, one bit per port

    logic [num_ports-1:0] port_pending;
    logic [num_ports-1:0] port_masked;
    logic [num_ports-1:0] port_clear;
    logic [num_ports-1:0] port_unmasked;

    generate
        for (genvar p = 0; p < num_ports; p++) begin : g_port
            localparam int bit_pos = port_irq_first_bit + p;
            logic pending;
            logic masked;

            assign port_clear[p] = wr_status && reg_req.wdata[bit_pos];

            // set wins over a same-cycle write-one clear
            always_ff @(posedge clk or posedge sys_rst) begin
                if (sys_rst) begin
                    pending <= irq_status_reset[bit_pos];
                end else if (link_change[p]) begin
                    pending <= 1'b1;
                end else if (port_clear[p]) begin
                    pending <= 1'b0;
                end
            end

            always_ff @(posedge clk or posedge sys_rst) begin
                if (sys_rst) begin
                    masked <= irq_mask_reset[bit_pos];
                end else if (wr_mask) begin
                    masked <= reg_req.wdata[bit_pos];
                end
            end

            assign port_pending[p] = pending;
            assign port_masked[p] = masked;
            assign port_unmasked[p] = pending && !masked;
        end
    endgenerate

    // byte views, reserved positions read zero and ignore writes
    always_comb begin
        link_change_irq_status = 8'h00;
        link_change_irq_mask = 8'h00;
        link_change_irq_status[port_irq_first_bit +: num_ports] = port_pending;
        link_change_irq_mask[port_irq_first_bit +: num_ports] = port_masked;
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt output

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |port_unmasked;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // priority map, one field per tag

    localparam int num_tags = 1 << tag_width;
    localparam int map_bits = num_tags * prio_width;
    localparam int low_fields = 8 / prio_width;
    localparam logic [map_bits-1:0] map_reset = {tag_priority_map_high_reset, tag_priority_map_low_reset};

    logic [map_bits-1:0] map_fields;
    logic [map_bits-1:0] map_wdata;
    logic [num_tags-1:0] map_load;

    // each field takes its slice of the byte written to its map register
    assign map_wdata = {reg_req.wdata, reg_req.wdata};

    generate
        for (genvar t = 0; t < num_tags; t++) begin : g_tag
            localparam int lsb = t * prio_width;
            logic [prio_width-1:0] field;

            if (t < low_fields) begin : g_low
                assign map_load[t] = wr_map_low;
            end else begin : g_high
                assign map_load[t] = wr_map_high;
            end

            always_ff @(posedge clk or posedge sys_rst) begin
                if (sys_rst) begin
                    field <= map_reset[lsb +: prio_width];
                end else if (map_load[t]) begin
                    field <= map_wdata[lsb +: prio_width];
                end
            end

            assign map_fields[lsb +: prio_width] = field;
        end
    endgenerate

    // named view of each tag's field
    logic [prio_width-1:0] tag_zero_priority;
    logic [prio_width-1:0] tag_one_priority;
    logic [prio_width-1:0] tag_two_priority;
    logic [prio_width-1:0] tag_three_priority;
    logic [prio_width-1:0] tag_four_priority;
    logic [prio_width-1:0] tag_five_priority;
    logic [prio_width-1:0] tag_six_priority;
    logic [prio_width-1:0] tag_seven_priority;

    assign tag_zero_priority = map_fields[1:0];
    assign tag_one_priority = map_fields[3:2];
    assign tag_two_priority = map_fields[5:4];
    assign tag_three_priority = map_fields[7:6];
    assign tag_four_priority = map_fields[9:8];
    assign tag_five_priority = map_fields[11:10];
    assign tag_six_priority = map_fields[13:12];
    assign tag_seven_priority = map_fields[15:14];

    assign tag_priority_map_low = {tag_three_priority, tag_two_priority, tag_one_priority, tag_zero_priority};
    assign tag_priority_map_high = {tag_seven_priority, tag_six_priority, tag_five_priority, tag_four_priority};

    tag_priority_lookup tag_priority_lookup_i (
        .clk(clk),
        .sys_rst(sys_rst),
        .map_low(tag_priority_map_low),
        .map_high(tag_priority_map_high),
        .frame_in(frame_in),
        .frame_out(frame_out)
    );

    ////////////////////////////////////////////////////////////////////////
    // read path

    always_comb begin
        next_rd_data = 8'h00;
        if (sel_indirect) begin
            next_rd_data = indirect_data_byte0;
        end
        if (sel_status) begin
            next_rd_data = link_change_irq_status;
        end
        if (sel_mask) begin
            next_rd_data = link_change_irq_mask;
        end
        if (sel_map_low) begin
            next_rd_data = tag_priority_map_low;
        end
        if (sel_map_high) begin
            next_rd_data = tag_priority_map_high;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rd_valid <= 1'b0;
        end else begin
            rd_valid <= reg_req.rd;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rd_data <= 8'h00;
        end else if (reg_req.rd) begin
            rd_data <= next_rd_data;
        end
    end

endmodule
`default_nettype wire

/* File: dv/switch_regs_sva.sv */
// checker for the switch register slice
`timescale 1ns/100ps
`default_nettype none
module switch_regs_sva
    import switch_regs_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // watched ports
    input wire reg_req_type reg_req,
    input wire logic [7:0] rd_data,
    input wire logic rd_valid,
    input wire logic [num_ports-1:0] link_up,
    input wire logic irq,
    input wire frame_tag_type frame_in,
    input wire frame_prio_type frame_out,
    input wire logic [7:0] indirect_data_low
);
    logic [7:0] mask;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst)
            mask <= 8'h00;
        else if (reg_req.wr && reg_req.addr == link_change_irq_mask_addr)
            mask <= reg_req.wdata & port_irq_field;
    end
    ////////////////////////////////////////////////////////////////////////
    idata_write_a: assert property (
        reg_req.wr && reg_req.addr == indirect_data_byte0_addr |=> indirect_data_low == $past(reg_req.wdata))
        else $error("indirect byte not written");
    idata_hold_a: assert property (
        !(reg_req.wr && reg_req.addr == indirect_data_byte0_addr) |=> $stable(indirect_data_low))
        else $error("indirect byte changed");
    rsvd_zero_a: assert property (
        reg_req.rd && reg_req.addr[7:1] == 7'h3e |=> rd_valid && (rd_data & ~port_irq_field) == 8'h00)
        else $error("reserved bits read nonzero");
    unmapped_read_a: assert property (
        reg_req.rd && reg_req.addr == 8'h79 |=> rd_data == 8'h00)
        else $error("unmapped read nonzero");
    link_irq_a: assert property (
        |((link_up ^ $past(link_up)) & ~mask[2:1]) |-> ##2 irq)
        else $error("link change gave no irq");
    irq_clear_a: assert property (
        reg_req.wr && reg_req.addr == link_change_irq_status_addr && reg_req.wdata[2:1] == 2'b11
        && link_up == $past(link_up) ##1 link_up == $past(link_up) |=> !irq)
        else $error("irq not cleared");
    irq_mask_a: assert property (
        $past(mask[2:1]) == 2'b11 |-> !irq)
        else $error("masked irq raised");
    rd_hold_a: assert property (
        !reg_req.rd |=> $stable(rd_data) && !rd_valid)
        else $error("read data moved");
    frame_pulse_a: assert property (
        frame_in.valid |=> frame_out.valid ##1 (frame_out.valid == $past(frame_in.valid)))
        else $error("frame result missing");
    cover property (irq);
    cover property (frame_out.valid && frame_out.prio == 2'h3);
    cover property (rd_valid && rd_data == port_irq_field);
endmodule
bind switch_irq_and_priority_regs switch_regs_sva switch_regs_sva_i (.clk, .sys_rst, .reg_req, .rd_data,
    .rd_valid, .link_up, .irq, .frame_in, .frame_out, .indirect_data_low);
`default_nettype wire

/* File: dv/switch_irq_and_priority_regs_tb.sv */
// self-checking bench for the switch register slice
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin n_errors++; \
    $display("mismatch %s exp %h got %h", n, e, g); end end
module switch_irq_and_priority_regs_tb
    import switch_regs_pkg::*;
;
    logic clk, sys_rst, rd_valid, irq;
    reg_req_type req;
    logic [7:0] rd_data, idl, pm;
    logic [1:0] link;
    frame_tag_type fin;
    frame_prio_type fout;
    int n_errors, comparisons;
    switch_irq_and_priority_regs switch_irq_and_priority_regs_i (.clk(clk), .sys_rst(sys_rst), .reg_req(req),
        .rd_data(rd_data), .rd_valid(rd_valid), .link_up(link), .irq(irq), .frame_in(fin), .frame_out(fout),
        .indirect_data_low(idl));
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #1 req = '{1'b1, 1'b0, a, d};
        @(posedge clk);
        #1 req = '0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        #1 req = '{1'b0, 1'b1, a, 8'h00};
        @(posedge clk);
        #1 req = '0;
        `CHK("rd_valid", 1'b1, rd_valid)
        `CHK("rd_data", e, rd_data)
    endtask
    task automatic frames(input logic [15:0] map);
        for (int t = 0; t < 8; t++) begin
            @(posedge clk);
            #1 fin = '{1'b1, t[2:0]};
            @(posedge clk);
            #1 fin = '0;
            `CHK("prio", map[2*t +: 2], fout.prio)
            `CHK("prio_valid", 1'b1, fout.valid)
        end
    endtask
    task automatic print_verdict;
        if (n_errors == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 0;
        forever #2 clk = ~clk;
    end
    initial begin
        repeat (3000) @(posedge clk);
        n_errors++;
        print_verdict;
    end
    initial begin
        n_errors = 0;
        comparisons = 0;
        sys_rst = 1;
        req = '0;
        link = 2'b00;
        fin = '0;
        repeat (5) @(posedge clk);
        #1 sys_rst = 0;
        rd(indirect_data_byte0_addr, 8'h00);
        rd(link_change_irq_mask_addr, 8'h00);
        rd(link_change_irq_status_addr, 8'h00);
        rd(tag_priority_map_low_addr, 8'h50);
        rd(tag_priority_map_high_addr, 8'hfa);
        rd(8'h79, 8'h00);
        frames(16'hfa50);
        wr(tag_priority_map_low_addr, 8'he4);
        wr(tag_priority_map_high_addr, 8'h1b);
        frames(16'h1be4);
        wr(indirect_data_byte0_addr, 8'ha5);
        rd(indirect_data_byte0_addr, 8'ha5);
        `CHK("indirect", 8'ha5, idl)
        wr(link_change_irq_mask_addr, 8'hff);
        rd(link_change_irq_mask_addr, 8'h06);
        wr(link_change_irq_mask_addr, 8'h00);
        for (int p = 0; p < 2; p++) begin
            pm = 8'h02 << p;
            link[p] = ~link[p];
            repeat (3) @(posedge clk);
            #1 `CHK("irq", 1'b1, irq)
            rd(link_change_irq_status_addr, pm);
            wr(link_change_irq_status_addr, 8'h00);
            rd(link_change_irq_status_addr, pm);
            wr(link_change_irq_mask_addr, pm);
            repeat (2) @(posedge clk);
            #1 `CHK("irq_masked", 1'b0, irq)
            wr(link_change_irq_mask_addr, 8'h00);
            wr(link_change_irq_status_addr, 8'hff);
            rd(link_change_irq_status_addr, 8'h00);
            `CHK("irq_cleared", 1'b0, irq)
        end
        @(posedge clk);
        #1 req = '{1'b1, 1'b0, link_change_irq_status_addr, 8'h06};
        link[0] = ~link[0];
        @(posedge clk);
        #1 req = '0;
        rd(link_change_irq_status_addr, 8'h02);
        `CHK("irq_set_wins", 1'b1, irq)
        print_verdict;
    end
endmodule
`default_nettype wire
